/* File: ifer_edge_detect.sv */
// Purpose: selectable edge detector for the external request pins
// Assumes: pins synchronous to clk_i
// Notes:   one pulse per detected edge
`timescale 1ns/1ps
module ifer_edge_detect (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [ifer_pkg::NPIN-1:0] pin_i,
    input  wire logic [ifer_pkg::NPIN-1:0] rise_sel_i,
    output logic      [ifer_pkg::NPIN-1:0] edge_o
);
    import ifer_pkg::*;

    logic [NPIN-1:0] prev_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= '1;
        end else begin
            prev_r <= pin_i;
        end
    end

    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            edge_o[i] = rise_sel_i[i] ? (pin_i[i] & ~prev_r[i])
                                      : (~pin_i[i] & prev_r[i]);
        end
    end
endmodule : ifer_edge_detect

/* File: ifer_pkg.sv */
// Purpose: constants for the interrupt flag and enable register block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   register values sit in the low byte, upper bits read zero
package ifer_pkg;
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 32;
    localparam int unsigned RW = 8;
    localparam int unsigned NPIN = 4;

    localparam logic [AW-1:0] OFS_ENABLE    = 4'h0;
    localparam logic [AW-1:0] OFS_FLAGS_ONE = 4'h4;
    localparam logic [AW-1:0] OFS_FLAGS_TWO = 4'h8;
    localparam logic [AW-1:0] OFS_CTRL      = 4'hC;

    localparam int unsigned BIT_TMR = 5;
    localparam int unsigned BIT_DT  = 7;
    localparam int unsigned BIT_RTC = 6;

    localparam logic [RW-1:0] TWO_FIXED_ONES = 8'h1F;
    localparam logic [RW-1:0] ONE_FIXED_ONES = 8'h30;
    localparam logic [RW-1:0] ONE_FLAG_MASK  = 8'hCF;
    localparam logic [RW-1:0] PIN_MASK       = 8'h0F;

    // control register: [3:0] pin interrupt select, [7:4] edge select
    localparam int unsigned CTRL_EDGE_LSB = 4;
    localparam logic [RW-1:0] CTRL_RESET  = 8'h00;
endpackage : ifer_pkg

/* File: ifer_regs.sv */
// Purpose: second enable register and two request flag registers
// Assumes: classic wishbone slave, one-cycle registered ack
// Notes:   events are one-cycle pulses; set wins over a clearing write
//
// How it works
// - timer request reaches cpu only with enable bit 5 set; resets 0.
// - enable and flags two read 0 in bits 7:6, 1 in 4:0.
// - flags one bits 5:4 always read 1, writes ignored.
// - sleep direct transition with direct_transition_on sets bit 7.
// - rtc counter overflow sets flags one bit 6.
// - selected edge on interrupt-configured pin sets flags one bits 3:0.
// - timer overflow sets flags two bit 5.
// - flags reset 0, stay set, cleared only by writing 0.
// - request coinciding with clearing write still taken afterwards.
// - edge select 0 means falling edge, 1 means rising edge.
`timescale 1ns/1ps
module ifer_regs (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [ifer_pkg::AW-1:0]   wb_adr_i,
    input  wire logic [ifer_pkg::DW-1:0]   wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [ifer_pkg::DW-1:0]   wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      sleep_direct_i,
    input  wire logic                      direct_transition_on_i,
    input  wire logic                      rtc_overflow_i,
    input  wire logic                      timer_overflow_i,
    input  wire logic [ifer_pkg::NPIN-1:0] ext_pin_i,
    input  wire logic [ifer_pkg::RW-1:0]   irq_enable_one_i,
    output logic                           timer_irq_o,
    output logic                           ext_irq_o,
    output logic      [ifer_pkg::RW-1:0]   flags_one_o
);
    import ifer_pkg::*;

    logic            timer_overflow_irq_enable_r;
    logic [RW-1:0]   flags_one_r;
    logic            timer_overflow_flag_r;
    logic [RW-1:0]   ctrl_r;
    logic            ack_r;
    logic [DW-1:0]   rdat_r;
    logic [NPIN-1:0] pin_edge;
    logic            req;
    logic            wr_lo;
    logic [RW-1:0]   one_set;

    function automatic logic [RW-1:0] read_reg(input logic [AW-1:0] a,
                                               input logic en,
                                               input logic [RW-1:0] f1,
                                               input logic f2,
                                               input logic [RW-1:0] c);
        logic [RW-1:0] v;
        v = '0;
        unique case (a)
            OFS_ENABLE:    v = TWO_FIXED_ONES | (RW'(en) << BIT_TMR);
            OFS_FLAGS_ONE: v = (f1 & ONE_FLAG_MASK) | ONE_FIXED_ONES;
            OFS_FLAGS_TWO: v = TWO_FIXED_ONES | (RW'(f2) << BIT_TMR);
            OFS_CTRL:      v = c;
            default:       v = '0;
        endcase
        return v;
    endfunction : read_reg

    assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_lo = req & wb_we_i & wb_sel_i[0];

    ifer_edge_detect u_edge (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (ext_pin_i),
        .rise_sel_i (ctrl_r[CTRL_EDGE_LSB +: NPIN]),
        .edge_o     (pin_edge)
    );

    always_comb begin
        one_set = '0;
        one_set[BIT_DT]   = sleep_direct_i & direct_transition_on_i;
        one_set[BIT_RTC]  = rtc_overflow_i;
        one_set[NPIN-1:0] = pin_edge & ctrl_r[NPIN-1:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= '0;
        end else begin
            ack_r  <= req;
            rdat_r <= {{(DW-RW){1'b0}}, read_reg(wb_adr_i,
                        timer_overflow_irq_enable_r, flags_one_r,
                        timer_overflow_flag_r, ctrl_r)};
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_overflow_irq_enable_r <= 1'b0;
        end else if (wr_lo && wb_adr_i == OFS_ENABLE) begin
            timer_overflow_irq_enable_r <= wb_dat_i[BIT_TMR];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_lo && wb_adr_i == OFS_CTRL) begin
            ctrl_r <= wb_dat_i[RW-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_one_r <= '0;
        end else if (wr_lo && wb_adr_i == OFS_FLAGS_ONE) begin
            flags_one_r <= ((flags_one_r & wb_dat_i[RW-1:0]) | one_set)
                           & ONE_FLAG_MASK;
        end else begin
            flags_one_r <= (flags_one_r | one_set) & ONE_FLAG_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_overflow_flag_r <= 1'b0;
        end else if (wr_lo && wb_adr_i == OFS_FLAGS_TWO) begin
            timer_overflow_flag_r <= (timer_overflow_flag_r
                                      & wb_dat_i[BIT_TMR])
                                     | timer_overflow_i;
        end else begin
            timer_overflow_flag_r <= timer_overflow_flag_r
                                     | timer_overflow_i;
        end
    end

    assign timer_irq_o = timer_overflow_flag_r
                         & timer_overflow_irq_enable_r;
    // first-register sources use first enable register
    assign ext_irq_o   = |(flags_one_r & irq_enable_one_i & ONE_FLAG_MASK);
    assign flags_one_o = flags_one_r;

    // assertions

    property p_tmr_gate;
        @(posedge clk_i) disable iff (rst_i)
        (wr_lo && wb_adr_i == OFS_ENABLE && !wb_dat_i[BIT_TMR])
        |=> !timer_irq_o;
    endproperty
    a_tmr_gate: assert property (p_tmr_gate)
        else $error("timer request without flag and enable");

    property p_reserved_two;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && (wb_adr_i == OFS_ENABLE
                             || wb_adr_i == OFS_FLAGS_TWO))
        |=> (wb_dat_o[RW-1:0] & ~(RW'(1) << BIT_TMR)) == TWO_FIXED_ONES;
    endproperty
    a_reserved_two: assert property (p_reserved_two)
        else $error("reserved bits wrong in enable or flags two");

    property p_reserved_one;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == OFS_FLAGS_ONE)
        |=> (wb_dat_o[RW-1:0] & ONE_FIXED_ONES) == ONE_FIXED_ONES;
    endproperty
    a_reserved_one: assert property (p_reserved_one)
        else $error("flags one reserved bits not one");

    property p_dt_set;
        @(posedge clk_i) disable iff (rst_i)
        (sleep_direct_i && direct_transition_on_i) |=> flags_one_r[BIT_DT];
    endproperty
    a_dt_set: assert property (p_dt_set)
        else $error("direct transition flag not set");

    property p_rtc_set;
        @(posedge clk_i) disable iff (rst_i)
        rtc_overflow_i |=> flags_one_r[BIT_RTC];
    endproperty
    a_rtc_set: assert property (p_rtc_set)
        else $error("rtc flag not set");

    property p_pin_set;
        @(posedge clk_i) disable iff (rst_i)
        (pin_edge[0] && ctrl_r[0]) |=> flags_one_r[0];
    endproperty
    a_pin_set: assert property (p_pin_set)
        else $error("pin flag not set on edge");

    property p_tmr_set;
        @(posedge clk_i) disable iff (rst_i)
        timer_overflow_i |=> timer_overflow_flag_r;
    endproperty
    a_tmr_set: assert property (p_tmr_set)
        else $error("timer flag not set");

    property p_sticky;
        @(posedge clk_i) disable iff (rst_i)
        (timer_overflow_flag_r && !(wr_lo && wb_adr_i == OFS_FLAGS_TWO
                                    && !wb_dat_i[BIT_TMR]))
        |=> timer_overflow_flag_r;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("timer flag lost without clearing write");

    property p_edge_sel;
        @(posedge clk_i) disable iff (rst_i)
        (!ctrl_r[CTRL_EDGE_LSB] && $fell(ext_pin_i[0])) |-> pin_edge[0];
    endproperty
    a_edge_sel: assert property (p_edge_sel)
        else $error("falling edge missed");

    property p_en_store;
        @(posedge clk_i) disable iff (rst_i)
        (wr_lo && wb_adr_i == OFS_ENABLE)
        |=> timer_overflow_irq_enable_r == $past(wb_dat_i[BIT_TMR]);
    endproperty
    a_en_store: assert property (p_en_store)
        else $error("enable bit not stored");

    property p_dt_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!flags_one_r[BIT_DT]
         && !(sleep_direct_i && direct_transition_on_i))
        |=> !flags_one_r[BIT_DT];
    endproperty
    a_dt_quiet: assert property (p_dt_quiet)
        else $error("direct transition flag set without event");

    property p_rtc_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!flags_one_r[BIT_RTC] && !rtc_overflow_i)
        |=> !flags_one_r[BIT_RTC];
    endproperty
    a_rtc_quiet: assert property (p_rtc_quiet)
        else $error("rtc flag set without overflow");

    property p_pin_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!ctrl_r[0] && !flags_one_r[0]) |=> !flags_one_r[0];
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("pin flag set while pin not selected");

    property p_tmr_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!timer_overflow_flag_r && !timer_overflow_i)
        |=> !timer_overflow_flag_r;
    endproperty
    a_tmr_quiet: assert property (p_tmr_quiet)
        else $error("timer flag set without overflow");

    property p_rtc_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr_lo && wb_adr_i == OFS_FLAGS_ONE && !wb_dat_i[BIT_RTC]
         && !rtc_overflow_i)
        |=> !flags_one_r[BIT_RTC];
    endproperty
    a_rtc_clear: assert property (p_rtc_clear)
        else $error("rtc flag not cleared by writing zero");

    property p_tmr_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr_lo && wb_adr_i == OFS_FLAGS_TWO && !wb_dat_i[BIT_TMR]
         && !timer_overflow_i)
        |=> !timer_overflow_flag_r;
    endproperty
    a_tmr_clear: assert property (p_tmr_clear)
        else $error("timer flag not cleared by writing zero");

    property p_set_wins;
        @(posedge clk_i) disable iff (rst_i)
        (wr_lo && wb_adr_i == OFS_FLAGS_TWO && timer_overflow_i)
        |=> timer_overflow_flag_r;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("request lost under clearing write");

    property p_keep_one;
        @(posedge clk_i) disable iff (rst_i)
        (flags_one_r[BIT_RTC] && wr_lo && wb_adr_i == OFS_FLAGS_ONE
         && wb_dat_i[BIT_RTC])
        |=> flags_one_r[BIT_RTC];
    endproperty
    a_keep_one: assert property (p_keep_one)
        else $error("writing one cleared a flag");

    property p_ext_gate;
        @(posedge clk_i) disable iff (rst_i)
        ((flags_one_r & ONE_FLAG_MASK) == '0) |-> !ext_irq_o;
    endproperty
    a_ext_gate: assert property (p_ext_gate)
        else $error("pin request without any flag");

    property p_edge_rise;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl_r[CTRL_EDGE_LSB] && $rose(ext_pin_i[0])) |-> pin_edge[0];
    endproperty
    a_edge_rise: assert property (p_edge_rise)
        else $error("rising edge missed");
endmodule : ifer_regs

/* File: ifer_src.sv */
// Purpose: event and pin source facing the flag block
// Assumes: each toggle of tog_i asks for one event of kind_i
// Notes:   kinds 0 sleep, 1 rtc, 2 timer, 4 to 7 toggle a pin
`timescale 1ns/1ps
module ifer_src (
    input  wire logic       clk_i,
    input  wire logic       tog_i,
    input  wire logic [2:0] kind_i,
    output logic            sleep_o,
    output logic            rtc_o,
    output logic            tmr_o,
    output logic [3:0]      pin_o
);
    logic       tog_r = 1'h0;
    // pins idle high, matching the edge history at reset
    logic [3:0] pin_r = 4'hF;
    logic       hit;
    assign hit     = tog_i ^ tog_r;
    assign sleep_o = hit && kind_i == 3'h0;
    assign rtc_o   = hit && kind_i == 3'h1;
    assign tmr_o   = hit && kind_i == 3'h2;
    assign pin_o   = pin_r;
    always_ff @(posedge clk_i) begin
        tog_r <= tog_i;
        if (hit && kind_i[2]) begin
            pin_r[kind_i[1:0]] <= ~pin_r[kind_i[1:0]];
        end
    end
endmodule : ifer_src

/* File: test_ifer_regs.sv */
// Purpose: self-checking bench for the flag and enable registers
// Assumes: read data checked by a watcher against queued notes
// Notes:   pin edge selects come from a seeded random value
`timescale 1ns/1ps
module test_ifer_regs;
    import ifer_pkg::*;
    logic            clk_i = '0, rst_i = '1, cyc = '0, stb = '0;
    logic            we = '0, tog = '0, dt_on = '0;
    logic [AW-1:0]   adr = '0;
    logic [DW-1:0]   wd = '0, rdat;
    logic [2:0]      kind = '0;
    logic [RW-1:0]   ien1 = '0, fl1, ctl, exp1 = '0;
    logic            ack, tirq, eirq, sd, rtc, tmr;
    logic [NPIN-1:0] pin;
    logic [DW-1:0]   q[$];
    int              fails = 0, total_checks = 0, seed = 45362;
    always #12.5 clk_i = ~clk_i;
    ifer_src SRC (.clk_i(clk_i), .tog_i(tog), .kind_i(kind), .sleep_o(sd),
        .rtc_o(rtc), .tmr_o(tmr), .pin_o(pin));
    ifer_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd),
        .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sleep_direct_i(sd), .direct_transition_on_i(dt_on),
        .rtc_overflow_i(rtc), .timer_overflow_i(tmr), .ext_pin_i(pin),
        .irq_enable_one_i(ien1), .timer_irq_o(tirq), .ext_irq_o(eirq),
        .flags_one_o(fl1));
    task automatic chk(string n, logic [DW-1:0] e, logic [DW-1:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // one classic cycle; hit fires an event in the request cycle
    task automatic bus(logic w, logic [AW-1:0] a, logic [DW-1:0] d,
                       logic hit);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we  <= w;
        adr <= a;
        wd  <= d;
        if (hit) tog <= ~tog;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        if (n >= 20) begin
            fails++;
            close_out();
        end
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : bus
    task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
        bus(1'h1, a, d, 1'h0);
    endtask : wr
    task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
        q.push_back(e);
        bus(1'h0, a, '0, 1'h0);
    endtask : rd
    task automatic ev(logic [2:0] k);
        @(posedge clk_i);
        kind <= k;
        tog  <= ~tog;
        repeat (3) @(posedge clk_i);
    endtask : ev
    always @(posedge clk_i) begin
        if (ack === 1'h1 && we === 1'h0) chk("rdata", q.pop_front(), rdat);
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(OFS_ENABLE, 32'h1F);
        rd(OFS_FLAGS_ONE, 32'h30);
        rd(OFS_FLAGS_TWO, 32'h1F);
        wr(OFS_ENABLE, 32'hFF);
        rd(OFS_ENABLE, 32'h3F);
        wr(OFS_FLAGS_ONE, 32'hFF);
        wr(OFS_FLAGS_TWO, 32'hFF);
        rd(OFS_FLAGS_ONE, 32'h30);
        rd(OFS_FLAGS_TWO, 32'h1F);
        rd(4'h2, 32'h0);
        $display("register test done");
        ev(3'h2);
        rd(OFS_FLAGS_TWO, 32'h3F);
        chk("timer_irq", 32'h1, {31'h0, tirq});
        wr(OFS_FLAGS_TWO, 32'hFF);
        rd(OFS_FLAGS_TWO, 32'h3F);
        bus(1'h1, OFS_FLAGS_TWO, 32'h0, 1'h1);
        rd(OFS_FLAGS_TWO, 32'h3F);
        wr(OFS_ENABLE, 32'h0);
        chk("timer_irq", 32'h0, {31'h0, tirq});
        wr(OFS_FLAGS_TWO, 32'h0);
        rd(OFS_FLAGS_TWO, 32'h1F);
        ev(3'h0);
        rd(OFS_FLAGS_ONE, 32'h30);
        dt_on <= 1'h1;
        ev(3'h0);
        rd(OFS_FLAGS_ONE, 32'hB0);
        ev(3'h1);
        rd(OFS_FLAGS_ONE, 32'hF0);
        wr(OFS_FLAGS_ONE, 32'h7F);
        rd(OFS_FLAGS_ONE, 32'h70);
        wr(OFS_FLAGS_ONE, 32'h0);
        $display("event test done");
        ctl = 8'($random(seed));
        wr(OFS_CTRL, {24'h0, ctl});
        for (int i = 0; i < NPIN; i++) begin
            ev(3'(4 + i));
            exp1[i] = ctl[i] & ~ctl[CTRL_EDGE_LSB + i];
            rd(OFS_FLAGS_ONE, {24'h0, exp1 | ONE_FIXED_ONES});
            ev(3'(4 + i));
            exp1[i] = ctl[i];
            rd(OFS_FLAGS_ONE, {24'h0, exp1 | ONE_FIXED_ONES});
        end
        chk("flags_one_o", {24'h0, exp1}, {24'h0, fl1});
        ien1 <= 8'($random(seed));
        repeat (2) @(posedge clk_i);
        chk("ext_irq", {31'h0, |(exp1 & ien1)}, {31'h0, eirq});
        $display("pin test done");
        close_out();
    end
endmodule : test_ifer_regs
